// file: design/dual_mode_host_serial_port.sv
// host serial port: spi slave by default, locks to uart on any uart byte with a high stop bit
// assumes a command core answers on the resp port; link clock is the spi clock
// Notes on behaviour
// - spi after reset, uart lock on byte
// - never send without a prior command
// - every command gets some response
// - ready open drain, read back in uart
// - uart answers wait while host holds ready
// - ready low within 20 us per byte
// - each ready low lasts at least 1 us
// - ready back high within command deadline
// - ready low 1 ms after reset
// - clock idles high, rise samples, fall shifts
// - miso floats while select high
// - ignore commands during intermediate responses
// - sleep command, wake on 10 us low
// - baud setting applies only after reset
// - uart answers sent on own timing
// - either side may hold ready low
// - uart tx floats after each byte
// - uart frame 8n1
`timescale 1ns/1ps
module dual_mode_host_serial_port import hsp_pkg::*; #(
	parameter int RESET_LOW_CYC  = RESET_LOW_DEF,
	parameter int RESP_CYC       = RESP_DEF,
	parameter int RESP_LONG_CYC  = RESP_LONG_DEF,
	parameter int RESP_SLEEP_CYC = RESP_SLEEP_DEF
) (
	input  wire logic              i_ref_clk,
	input  wire logic              i_reset,
	input  wire logic              i_spi_clk,
	input  wire logic              i_spi_ss_n,
	input  wire logic              i_spi_mosi,
	output logic                   o_spi_miso,
	output logic                   o_spi_miso_oe,
	input  wire logic              i_uart_rx,
	output logic                   o_uart_tx,
	output logic                   o_uart_tx_oe,
	input  wire logic              i_comm_ready_line,
	output logic                   o_comm_ready_line,
	output logic                   o_comm_ready_line_oe,
	input  wire logic              i_wake_sync_input,
	input  wire logic [BAUD_W-1:0] i_baud_rate_setting,
	output logic                   o_cmd_valid,
	output logic [7:0]             o_cmd_byte,
	input  wire logic              i_resp_valid,
	input  wire logic [7:0]        i_resp_byte,
	input  wire logic              i_resp_last,
	output logic                   o_resp_ready,
	output logic                   o_uart_mode,
	output logic                   o_asleep
);
	localparam int LOW_MIN_M1 = LOW_MIN_CYC - 1;

	byte_link_if bl ();

	logic [3:0]        sync1, sync2;
	logic              tgl_seen, rx_s, ready_in_s, wake_s;
	logic              captured, next_captured;
	logic [BAUD_W-1:0] baud_div, next_baud_div;
	rx_state_t         rx_state, next_rx_state;
	logic [BAUD_W-1:0] rx_cnt, next_rx_cnt;
	logic [2:0]        rx_bit, next_rx_bit;
	logic [7:0]        rx_shift, next_rx_shift;
	logic              urx_done, next_urx_done;
	logic              tx_busy, next_tx_busy, tx_go, tx_done, next_tx_done;
	logic [BAUD_W-1:0] tx_cnt, next_tx_cnt;
	logic [3:0]        tx_bit, next_tx_bit;
	logic [8:0]        tx_shift, next_tx_shift;
	logic              next_tx_line, next_tx_oe;
	ctl_state_t        state, next_state;
	logic [CNT_W-1:0]  wait_cnt, next_wait, wait_lim, next_lim, rst_cnt, next_rst_cnt;
	logic [11:0]       wake_cnt, next_wake_cnt;
	logic [8:0]        low_cnt, next_low_cnt;
	logic              uart_mode, next_uart_mode, ready_low, next_ready_low;
	logic              guard_done, is_sleep, next_is_sleep, launched, next_launched;
	logic              resp_last, next_resp_last, cmd_take, finish;
	logic [7:0]        resp_byte, next_resp_byte, next_cmd_byte;
	logic              next_cmd_valid, spi_done, rx_done;
	logic [7:0]        rx_data;

	spi_link u_spi (
		.i_spi_clk    (i_spi_clk),
		.i_reset      (i_reset),
		.i_spi_ss_n   (i_spi_ss_n),
		.i_spi_mosi   (i_spi_mosi),
		.o_spi_miso   (o_spi_miso),
		.o_spi_miso_oe(o_spi_miso_oe),
		.bl           (bl.link)
	);

	assign bl.tx_byte  = resp_byte;
	assign bl.link_off = uart_mode;
	assign o_uart_mode = uart_mode;
	assign o_comm_ready_line_oe = ready_low;
	assign o_comm_ready_line = 1'b0; // open drain: only ever pulls low

	// deadline for the answer, longer for slow commands
	function automatic logic [CNT_W-1:0] resp_limit(input logic [7:0] cmd);
		if (cmd == CMD_SETUPS || cmd == CMD_EE_CRC)
			return CNT_W'(RESP_LONG_CYC - 1);
		if (cmd == CMD_SLEEP)
			return CNT_W'(RESP_SLEEP_CYC - 1);
		return CNT_W'(RESP_CYC - 1);
	endfunction : resp_limit

	// pins and the spi toggle cross on two flops before any use
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			sync1    <= SYNC_RST;
			sync2    <= SYNC_RST;
			tgl_seen <= 1'b0;
		end else begin
			sync1    <= {bl.rx_tgl, i_wake_sync_input, i_comm_ready_line, i_uart_rx};
			sync2    <= sync1;
			tgl_seen <= sync2[3];
		end
	end
	assign rx_s       = sync2[0];
	assign ready_in_s = sync2[1];
	assign wake_s     = sync2[2];
	assign spi_done   = !uart_mode && (sync2[3] != tgl_seen);
	assign rx_done    = urx_done || spi_done;
	assign rx_data    = urx_done ? rx_shift : bl.rx_byte;

	// baud divisor caught once after reset release, frozen until next reset
	always_comb begin
		next_captured = 1'b1;
		next_baud_div = captured ? baud_div : i_baud_rate_setting;
	end

	// uart receiver: mid-bit sampling, lsb first, stop bit must be high
	always_comb begin
		next_rx_state = rx_state;
		next_rx_cnt   = (rx_cnt != '0) ? rx_cnt - BAUD_W'(1) : rx_cnt;
		next_rx_bit   = rx_bit;
		next_rx_shift = rx_shift;
		next_urx_done = 1'b0;
		case (rx_state)
			RX_IDLE: if (!rx_s && captured) begin
				next_rx_state = RX_START;
				next_rx_cnt   = baud_div >> 1;
			end
			RX_START: if (rx_cnt == '0) begin
				next_rx_state = rx_s ? RX_IDLE : RX_DATA;
				next_rx_cnt   = baud_div - BAUD_W'(1);
				next_rx_bit   = 3'h0;
			end
			RX_DATA: if (rx_cnt == '0) begin
				next_rx_shift = {rx_s, rx_shift[7:1]};
				next_rx_bit   = rx_bit + 3'h1;
				next_rx_cnt   = baud_div - BAUD_W'(1);
				if (rx_bit == 3'h7)
					next_rx_state = RX_STOP;
			end
			RX_STOP: if (rx_cnt == '0) begin
				next_rx_state = RX_IDLE;
				next_urx_done = rx_s;
			end
			default: next_rx_state = RX_IDLE;
		endcase
	end

	// uart transmitter: drives only while framing a byte
	always_comb begin
		next_tx_busy  = tx_busy;
		next_tx_cnt   = (tx_cnt != '0) ? tx_cnt - BAUD_W'(1) : tx_cnt;
		next_tx_bit   = tx_bit;
		next_tx_shift = tx_shift;
		next_tx_line  = o_uart_tx;
		next_tx_oe    = o_uart_tx_oe;
		next_tx_done  = 1'b0;
		if (tx_go) begin
			next_tx_busy  = 1'b1;
			next_tx_cnt   = baud_div - BAUD_W'(1);
			next_tx_bit   = 4'h0;
			next_tx_shift = {1'b1, resp_byte};
			next_tx_line  = 1'b0;
			next_tx_oe    = 1'b1;
		end else if (tx_busy && tx_cnt == '0) begin
			next_tx_cnt = baud_div - BAUD_W'(1);
			if (tx_bit == TX_STOP_BIT) begin
				next_tx_busy = 1'b0;
				next_tx_oe   = 1'b0;
				next_tx_line = 1'b1;
				next_tx_done = 1'b1;
			end else begin
				next_tx_line  = tx_shift[0];
				next_tx_shift = {1'b1, tx_shift[8:1]};
				next_tx_bit   = tx_bit + 4'h1;
			end
		end
	end

	// command sequencing and ready line pacing
	always_comb begin
		next_state     = state;
		next_wait      = wait_cnt + CNT_W'(1);
		next_lim       = wait_lim;
		next_is_sleep  = is_sleep;
		next_resp_byte = resp_byte;
		next_resp_last = resp_last;
		next_launched  = launched;
		next_wake_cnt  = 12'h000;
		next_cmd_valid = 1'b0;
		next_cmd_byte  = o_cmd_byte;
		next_uart_mode = uart_mode | urx_done;
		cmd_take       = 1'b0;
		finish         = 1'b0;
		tx_go          = 1'b0;
		case (state)
			ST_IDLE: cmd_take = rx_done;
			ST_WAIT: begin
				if (i_resp_valid && o_resp_ready) begin
					next_resp_byte = i_resp_byte;
					next_resp_last = i_resp_last;
					next_state     = ST_SEND;
				end else if (wait_cnt >= wait_lim) begin
					next_resp_byte = RESP_DEFAULT;
					next_resp_last = 1'b1;
					next_state     = ST_SEND;
				end
				next_launched = 1'b0;
			end
			ST_SEND: if (uart_mode) begin
				// host pulling ready low holds the answer back
				if (!launched && !tx_busy && ready_in_s && !ready_low) begin
					tx_go         = 1'b1;
					next_launched = 1'b1;
				end
				if (tx_done)
					finish = resp_last;
				if (tx_done && !resp_last) begin
					next_state = ST_WAIT;
					next_wait  = '0;
					next_lim   = CNT_W'(RESP_CYC - 1);
				end
			end else if (rx_done) begin
				if (!resp_last) begin
					next_state = ST_WAIT;
					next_wait  = '0;
					next_lim   = CNT_W'(RESP_CYC - 1);
				end else if (rx_data != CMD_NULL)
					cmd_take = 1'b1;
				else
					finish = 1'b1;
			end
			ST_SLEEP: begin
				next_wake_cnt = wake_s ? 12'h000 : wake_cnt + 12'h001;
				if (wake_cnt >= 12'(WAKE_LOW_CYC - 1))
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
		if (finish) begin
			next_state     = is_sleep ? ST_SLEEP : ST_IDLE;
			next_resp_byte = CMD_NULL;
		end
		if (cmd_take) begin
			next_state     = ST_WAIT;
			next_wait      = '0;
			next_lim       = resp_limit(rx_data);
			next_is_sleep  = (rx_data == CMD_SLEEP);
			next_cmd_valid = 1'b1;
			next_cmd_byte  = rx_data;
			next_resp_byte = CMD_NULL;
		end
		// ready: low on every byte, held a least time, freed when answer is set
		next_low_cnt = !ready_low ? 9'h000 : (low_cnt == 9'h1ff) ? low_cnt : low_cnt + 9'h001;
		next_rst_cnt = guard_done ? rst_cnt : rst_cnt + CNT_W'(1);
		next_ready_low = ready_low;
		if (rx_done)
			next_ready_low = 1'b1;
		else if (ready_low && low_cnt >= 9'(LOW_MIN_M1) && guard_done &&
			(state == ST_IDLE || state == ST_SEND))
			next_ready_low = 1'b0;
	end
	assign guard_done = (rst_cnt >= CNT_W'(RESET_LOW_CYC - 1));

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			captured <= 1'b0;
			baud_div <= '0;
			rx_state <= RX_IDLE;
			rx_cnt   <= '0;
			rx_bit   <= 3'h0;
			rx_shift <= 8'h00;
			urx_done <= 1'b0;
			tx_busy  <= 1'b0;
			tx_cnt   <= '0;
			tx_bit   <= 4'h0;
			tx_shift <= 9'h1ff;
			tx_done  <= 1'b0;
			o_uart_tx    <= 1'b1;
			o_uart_tx_oe <= 1'b0;
			state      <= ST_IDLE;
			wait_cnt   <= '0;
			wait_lim   <= '0;
			rst_cnt    <= '0;
			wake_cnt   <= 12'h000;
			low_cnt    <= 9'h000;
			uart_mode  <= 1'b0;
			ready_low  <= 1'b1;
			is_sleep   <= 1'b0;
			launched   <= 1'b0;
			resp_last  <= 1'b0;
			resp_byte  <= 8'h00;
			o_cmd_valid  <= 1'b0;
			o_cmd_byte   <= 8'h00;
			o_resp_ready <= 1'b0;
			o_asleep     <= 1'b0;
		end else begin
			captured <= next_captured;
			baud_div <= next_baud_div;
			rx_state <= next_rx_state;
			rx_cnt   <= next_rx_cnt;
			rx_bit   <= next_rx_bit;
			rx_shift <= next_rx_shift;
			urx_done <= next_urx_done;
			tx_busy  <= next_tx_busy;
			tx_cnt   <= next_tx_cnt;
			tx_bit   <= next_tx_bit;
			tx_shift <= next_tx_shift;
			tx_done  <= next_tx_done;
			o_uart_tx    <= next_tx_line;
			o_uart_tx_oe <= next_tx_oe;
			state      <= next_state;
			wait_cnt   <= next_wait;
			wait_lim   <= next_lim;
			rst_cnt    <= next_rst_cnt;
			wake_cnt   <= next_wake_cnt;
			low_cnt    <= next_low_cnt;
			uart_mode  <= next_uart_mode;
			ready_low  <= next_ready_low;
			is_sleep   <= next_is_sleep;
			launched   <= next_launched;
			resp_last  <= next_resp_last;
			resp_byte  <= next_resp_byte;
			o_cmd_valid  <= next_cmd_valid;
			o_cmd_byte   <= next_cmd_byte;
			o_resp_ready <= (next_state == ST_WAIT);
			o_asleep     <= (next_state == ST_SLEEP);
		end
	end

	property p_ready_after_byte;
		@(posedge i_ref_clk) disable iff (i_reset) rx_done |=> o_comm_ready_line_oe;
	endproperty
	a_ready_after_byte: assert property (p_ready_after_byte) else $error("ready not low");
	property p_ready_min_low;
		@(posedge i_ref_clk) disable iff (i_reset)
		$fell(o_comm_ready_line_oe) |-> $past(low_cnt) >= 9'(LOW_MIN_M1);
	endproperty
	a_ready_min_low: assert property (p_ready_min_low) else $error("ready low too short");
	property p_reset_low;
		@(posedge i_ref_clk) disable iff (i_reset) !guard_done |-> o_comm_ready_line_oe;
	endproperty
	a_reset_low: assert property (p_reset_low) else $error("ready freed in guard");
	property p_lock_cause;
		@(posedge i_ref_clk) disable iff (i_reset)
		$rose(uart_mode) |-> $past(urx_done) && !o_spi_miso_oe ##1 uart_mode;
	endproperty
	a_lock_cause: assert property (p_lock_cause) else $error("bad uart lock");
	property p_miso_off;
		@(posedge i_ref_clk) disable iff (i_reset) uart_mode |=> !o_spi_miso_oe;
	endproperty
	a_miso_off: assert property (p_miso_off) else $error("miso driven in uart");
	property p_tx_after_cmd;
		@(posedge i_ref_clk) disable iff (i_reset)
		$rose(o_uart_tx_oe) |-> $past(state) == ST_SEND && $past(ready_in_s);
	endproperty
	a_tx_after_cmd: assert property (p_tx_after_cmd) else $error("unsolicited tx");
	property p_tx_release;
		@(posedge i_ref_clk) disable iff (i_reset)
		$fell(o_uart_tx_oe) |-> o_uart_tx && $past(tx_bit) == TX_STOP_BIT;
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("tx float early");
	property p_deadline;
		@(posedge i_ref_clk) disable iff (i_reset)
		state == ST_WAIT && wait_cnt >= wait_lim |=> state != ST_WAIT;
	endproperty
	a_deadline: assert property (p_deadline) else $error("no answer by deadline");
	property p_ignore_mid;
		@(posedge i_ref_clk) disable iff (i_reset)
		state == ST_SEND && !uart_mode && rx_done && !resp_last |=> !o_cmd_valid;
	endproperty
	a_ignore_mid: assert property (p_ignore_mid) else $error("mid byte as command");
	property p_baud_frozen;
		@(posedge i_ref_clk) disable iff (i_reset) captured |=> $stable(baud_div);
	endproperty
	a_baud_frozen: assert property (p_baud_frozen) else $error("baud changed live");
endmodule : dual_mode_host_serial_port

// file: include/hsp_pkg.sv
// constants and types for the dual mode host serial port
// assumes a 250 MHz core clock; all timing counts derive from it
package hsp_pkg;
	localparam longint unsigned CLK_HZ        = 250_000_000;
	localparam longint unsigned NS_PER_S      = 1_000_000_000;
	localparam longint unsigned LOW_MIN_NS    = 1_000;
	localparam longint unsigned RESET_LOW_NS  = 1_000_000;
	localparam longint unsigned RESP_NS       = 1_000_000;
	localparam longint unsigned RESP_LONG_NS  = 20_000_000;
	localparam longint unsigned RESP_SLEEP_NS = 5_000_000;
	localparam longint unsigned WAKE_LOW_NS   = 10_000;
	// least times round up, longest times round down
	localparam int LOW_MIN_CYC    = int'((LOW_MIN_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int RESET_LOW_DEF  = int'((RESET_LOW_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int RESP_DEF       = int'((RESP_NS * CLK_HZ) / NS_PER_S);
	localparam int RESP_LONG_DEF  = int'((RESP_LONG_NS * CLK_HZ) / NS_PER_S);
	localparam int RESP_SLEEP_DEF = int'((RESP_SLEEP_NS * CLK_HZ) / NS_PER_S);
	localparam int WAKE_LOW_CYC   = int'((WAKE_LOW_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int CNT_W          = 24;
	localparam int BAUD_W         = 16;
	localparam logic [7:0] CMD_NULL     = 8'h00;
	localparam logic [7:0] CMD_SETUPS   = 8'h01;
	localparam logic [7:0] CMD_EE_CRC   = 8'h0e;
	localparam logic [7:0] CMD_SLEEP    = 8'h16;
	localparam logic [7:0] RESP_DEFAULT = 8'h00;
	localparam logic [3:0] TX_STOP_BIT  = 4'h9;
	localparam logic [3:0] SYNC_RST     = 4'h7;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SEND, ST_SLEEP} ctl_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : hsp_pkg

// file: include/byte_link_if.sv
// byte carrier between the core clock logic and the spi clock logic
// rx_byte is stable whenever rx_tgl is seen to change in the core
`timescale 1ns/1ps
interface byte_link_if;
	logic [7:0] rx_byte;
	logic       rx_tgl;
	logic [7:0] tx_byte;
	logic       link_off;
	modport link (output rx_byte, output rx_tgl, input tx_byte, input link_off);
	modport core (input rx_byte, input rx_tgl, output tx_byte, output link_off);
endinterface : byte_link_if

// file: design/spi_link.sv
// spi slave shifter running on the host's clock
// assumes clock idles high and select frames each byte
`timescale 1ns/1ps
module spi_link (
	input  wire logic  i_spi_clk,
	input  wire logic  i_reset,
	input  wire logic  i_spi_ss_n,
	input  wire logic  i_spi_mosi,
	output logic       o_spi_miso,
	output logic       o_spi_miso_oe,
	byte_link_if.link  bl
);
	logic       frame_rst;
	logic [2:0] bit_cnt;
	logic [2:0] next_bit_cnt;
	logic [6:0] shift;
	logic [6:0] next_shift;
	logic [7:0] next_rx_byte;
	logic       next_rx_tgl;

	// select high or uart lock drops any partial byte and floats miso
	assign frame_rst = i_reset | i_spi_ss_n | bl.link_off;

	// byte assembly, msb first, sampled on rising edge
	always_comb begin
		next_bit_cnt = bit_cnt + 3'h1;
		next_shift   = {shift[5:0], i_spi_mosi};
		next_rx_byte = bl.rx_byte;
		next_rx_tgl  = bl.rx_tgl;
		if (bit_cnt == 3'h7) begin
			next_rx_byte = {shift, i_spi_mosi};
			next_rx_tgl  = ~bl.rx_tgl;
		end
	end

	always_ff @(posedge i_spi_clk or posedge frame_rst) begin
		if (frame_rst) begin
			bit_cnt <= 3'h0;
			shift   <= 7'h00;
		end else begin
			bit_cnt <= next_bit_cnt;
			shift   <= next_shift;
		end
	end

	// toggle survives select, so only the chip reset clears it
	always_ff @(posedge i_spi_clk or posedge i_reset) begin
		if (i_reset) begin
			bl.rx_byte <= 8'h00;
			bl.rx_tgl  <= 1'b0;
		end else if (!i_spi_ss_n && !bl.link_off) begin
			bl.rx_byte <= next_rx_byte;
			bl.rx_tgl  <= next_rx_tgl;
		end
	end

	// shift out on falling edge; tx_byte is held still while ready is high
	always_ff @(negedge i_spi_clk or posedge frame_rst) begin
		if (frame_rst) begin
			o_spi_miso    <= 1'b0;
			o_spi_miso_oe <= 1'b0;
		end else begin
			o_spi_miso    <= bl.tx_byte[3'h7 - bit_cnt];
			o_spi_miso_oe <= 1'b1;
		end
	end

	property p_rx_count;
		// forward form: an attempt that spans a chip reset is dropped, not misjudged
		@(posedge i_spi_clk) disable iff (i_reset)
		!i_spi_ss_n && !bl.link_off && bit_cnt == 3'h7 |=> $changed(bl.rx_tgl);
	endproperty
	a_rx_count: assert property (p_rx_count) else $error("byte ended off count");
endmodule : spi_link

// file: testbench/host_model.sv
// host controller model: spi master and uart peer for the serial port
// assumes the bench builds the wired-and ready line with its pull-up
`timescale 1ns/1ps
module host_model #(
	parameter int BIT_NS             = 128,
	parameter int READY_LOW_GUARD_NS = 200,
	parameter int WAIT_LIMIT_NS      = 40_000,
	parameter int WAKE_NS            = 10_400
) (
	input  wire logic i_ready_line,
	input  wire logic i_miso_line,
	input  wire logic i_tx_line,
	output logic      o_spi_clk,
	output logic      o_spi_ss_n,
	output logic      o_spi_mosi,
	output logic      o_uart_rx,
	output logic      o_pull_ready
);
	// idle levels: clock high, select high, rx high, ready released
	initial begin
		o_spi_clk    = 1'b1;
		o_spi_ss_n   = 1'b1;
		o_spi_mosi   = 1'b1;
		o_uart_rx    = 1'b1;
		o_pull_ready = 1'b0;
	end

	// bounded poll, so a stuck line cannot hang the host
	task automatic wait_high(output int waited);
		waited = 0;
		while (i_ready_line !== 1'b1 && waited < WAIT_LIMIT_NS) begin
			#2;
			waited += 2;
		end
	endtask : wait_high

	// one byte msb first; nbits under 8 aborts the frame
	task automatic spi_xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx,
			output int waited);
		wait_high(waited);
		o_spi_ss_n = 1'b0;
		#6;
		rx = 8'h00;
		for (int i = 7; i > 7 - nbits; i--) begin
			o_spi_clk  = 1'b0;
			o_spi_mosi = tx[i];
			#6;
			o_spi_clk = 1'b1;
			rx[i]     = i_miso_line;
			#6;
		end
		o_spi_ss_n = 1'b1;
		o_spi_mosi = ~o_spi_mosi; // no stale data after the frame
		#(READY_LOW_GUARD_NS);
	endtask : spi_xfer

	// 8n1 lsb first; a bad stop goes high early so no false start follows
	task automatic uart_send(input logic [7:0] data, input logic stop_ok, output int waited);
		wait_high(waited);
		o_uart_rx = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			o_uart_rx = data[i];
			#(BIT_NS);
		end
		o_uart_rx = stop_ok;
		#(BIT_NS * 3 / 4);
		o_uart_rx = 1'b1;
		#(BIT_NS / 4 + READY_LOW_GUARD_NS);
	endtask : uart_send

	// wait for a start bit, then sample each bit at its middle
	task automatic uart_recv(output logic [7:0] data, output logic stop);
		int t;
		t = 0;
		while (i_tx_line !== 1'b0 && t < WAIT_LIMIT_NS) begin
			#2;
			t += 2;
		end
		#(BIT_NS + BIT_NS / 2);
		for (int i = 0; i < 8; i++) begin
			data[i] = i_tx_line;
			#(BIT_NS);
		end
		stop = i_tx_line;
	endtask : uart_recv

	task automatic hold_ready(input logic on);
		o_pull_ready = on;
	endtask : hold_ready

	// select low with no clocks; select doubles as the wake line
	task automatic wake();
		o_spi_ss_n = 1'b0;
		#(WAKE_NS);
		o_spi_ss_n = 1'b1;
	endtask : wake
endmodule : host_model

// file: testbench/tb.sv
// self-checking bench for the dual mode host serial port
// assumes host_model on the far side and a queue-fed response source
`timescale 1ns/1ps
module tb import hsp_pkg::*;;
	localparam int BAUD = 32;
	localparam int RESP = 2000;
	localparam int RESP_LONG = 4000;
	typedef struct packed {logic [7:0] cmd; logic [7:0] resp;} row_t;
	row_t       rows [4] = '{'{8'h0f, 8'hf0}, '{8'h06, 8'h5a}, '{8'h01, 8'ha5}, '{8'h0e, 8'h3c}};
	logic [7:0] dl_cmd [2] = '{8'h06, 8'h0e};
	int         dl_cyc [2] = '{RESP, RESP_LONG};
	logic              clk, rst, i_resp_valid, i_resp_last, stop;
	logic [7:0]        i_resp_byte, rx, last_cmd;
	logic [BAUD_W-1:0] baud;
	logic [8:0]        resp_q [$];
	int                errors, cmp_count, n_cmd, n_tx, low_cyc, w, n0;
	wire  logic        sclk, ss_n, mosi, urx, pull, miso, miso_oe, tx, tx_oe, rdy, rdy_oe;
	wire  logic        cmd_valid, resp_ready, uart_mode, asleep;
	wire  logic [7:0]  cmd_byte;
	// wired-and ready with pull-up; floating miso shows the inverse
	wire  logic        ready_line = (rdy_oe ? rdy : 1'b1) & ~pull;
	wire  logic        miso_line = miso_oe ? miso : ~miso;
	wire  logic        tx_line = tx_oe ? tx : 1'b1;

	dual_mode_host_serial_port #(.RESET_LOW_CYC(300), .RESP_CYC(RESP),
		.RESP_LONG_CYC(RESP_LONG), .RESP_SLEEP_CYC(3000)) dual_mode_host_serial_port_i (
		.i_ref_clk(clk), .i_reset(rst), .i_spi_clk(sclk), .i_spi_ss_n(ss_n),
		.i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_uart_rx(urx),
		.o_uart_tx(tx), .o_uart_tx_oe(tx_oe), .i_comm_ready_line(ready_line),
		.o_comm_ready_line(rdy), .o_comm_ready_line_oe(rdy_oe), .i_wake_sync_input(ss_n),
		.i_baud_rate_setting(baud), .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte),
		.i_resp_valid(i_resp_valid), .i_resp_byte(i_resp_byte), .i_resp_last(i_resp_last),
		.o_resp_ready(resp_ready), .o_uart_mode(uart_mode), .o_asleep(asleep));

	host_model #(.BIT_NS(BAUD * 4)) host_model_i (.i_ready_line(ready_line),
		.i_miso_line(miso_line), .i_tx_line(tx_line), .o_spi_clk(sclk), .o_spi_ss_n(ss_n),
		.o_spi_mosi(mosi), .o_uart_rx(urx), .o_pull_ready(pull));

	always #2 clk = ~clk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic final_report();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report

	// host events at odd ns, never on a core edge
	task automatic spi(input logic [7:0] t, input int nb);
		@(posedge clk);
		#1;
		host_model_i.spi_xfer(t, nb, rx, w);
		check(w < 40_000, 1);
		check(miso_oe, 1'b0);
	endtask : spi

	// response source: pop on handshake, present next entry after the edge
	always @(posedge clk) begin
		if (i_resp_valid === 1'b1 && resp_ready === 1'b1) void'(resp_q.pop_front());
		#1;
		i_resp_valid = resp_q.size() != 0;
		i_resp_byte = (resp_q.size() != 0) ? resp_q[0][7:0] : 8'h00;
		i_resp_last = (resp_q.size() != 0) ? resp_q[0][8] : 1'b0;
	end

	// command pulses and every ready-low span the device makes
	always @(posedge clk) begin
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			last_cmd = cmd_byte;
		end
		if (rdy_oe === 1'b1) low_cyc++;
		else begin
			if (low_cyc != 0) check(low_cyc >= LOW_MIN_CYC, 1);
			low_cyc = 0;
		end
	end

	always @(posedge tx_oe) n_tx++;

	initial begin
		#(400_000);
		errors++;
		final_report();
	end

	initial begin
		{clk, rst, i_resp_valid, i_resp_byte, i_resp_last, baud} = {2'b01, 10'h000, 16'h0020};
		{errors, cmp_count, n_cmd, n_tx, low_cyc} = '0;
		repeat (4) @(posedge clk);
		check(rdy_oe, 1'b1);
		#1 rst = 1'b0;
		@(posedge clk);
		#1 baud = 16'h0040;
		repeat (290) @(posedge clk);
		check(rdy_oe, 1'b1);
		// ordinary command and single-byte answer rows
		foreach (rows[k]) begin
			resp_q.push_back({1'b1, rows[k].resp});
			n0 = n_cmd;
			spi(rows[k].cmd, 8);
			check(n_cmd - n0, 1);
			check(last_cmd, rows[k].cmd);
			spi(8'h00, 8);
			check(rx, rows[k].resp);
		end
		// no answer offered: fallback byte by the deadline
		for (int j = 0; j < 2; j++) begin
			spi(dl_cmd[j], 8);
			spi(8'h00, 8);
			check(rx, 8'h00);
			check((w + 200) / 4 > dl_cyc[j] - 50 && (w + 200) / 4 < dl_cyc[j] + 300, 1);
		end
		resp_q.push_back({1'b0, 8'h11});
		resp_q.push_back({1'b1, 8'h22});
		n0 = n_cmd;
		spi(8'h07, 8);
		spi(8'h06, 8);
		check(rx, 8'h11);
		spi(8'h00, 8);
		check(rx, 8'h22);
		check(n_cmd - n0, 1);
		spi(8'h06, 4);
		repeat (20) @(posedge clk);
		check(n_cmd - n0, 1);
		resp_q.push_back({1'b1, 8'h99});
		spi(CMD_SLEEP, 8);
		spi(8'h00, 8);
		check(rx, 8'h99);
		repeat (50) @(posedge clk);
		check(asleep, 1'b1);
		#1 host_model_i.wake();
		repeat (20) @(posedge clk);
		check(asleep, 1'b0);
		check(n_tx, 0);
		// uart: broken stop bit first, then a good byte that locks
		n0 = n_cmd;
		#1 host_model_i.uart_send(8'h42, 1'b0, w);
		repeat (100) @(posedge clk);
		check(uart_mode, 1'b0);
		check(n_cmd - n0, 0);
		resp_q.push_back({1'b1, 8'hc3});
		#1 host_model_i.uart_send(8'h42, 1'b1, w);
		host_model_i.hold_ready(1'b1);
		repeat (1500) @(posedge clk);
		check(uart_mode, 1'b1);
		check(last_cmd, 8'h42);
		check(n_tx, 0);
		#1 host_model_i.hold_ready(1'b0);
		host_model_i.uart_recv(rx, stop);
		check({stop, rx}, {1'b1, 8'hc3});
		repeat (BAUD) @(posedge clk);
		check(tx_oe, 1'b0);
		check(n_tx, 1);
		n0 = n_cmd;
		spi(8'h06, 8);
		repeat (20) @(posedge clk);
		check(n_cmd - n0, 0);
		// mid-run reset: uart lock must clear and spi must answer again
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (4) @(posedge clk);
		check(uart_mode, 1'b0);
		check({rdy_oe, rdy, tx_oe, miso_oe}, 4'h8);
		#1 rst = 1'b0;
		resp_q.push_back({1'b1, 8'hf0});
		n0 = n_cmd;
		spi(8'h0f, 8);
		check(n_cmd - n0, 1);
		spi(8'h00, 8);
		check(rx, 8'hf0);
		final_report();
	end
endmodule : tb
